// file: drbac_alu.sv
// dual-rail byte alu slice with carry latches and rail check,
// reached over an ahb-lite slave
// assumes: one master on core_clk_i; numbered bit 0 (most significant)
// sits in vector/bus bit 0, numbered bit 7 in vector/bus bit 7
//
// The AHB-Lite slave port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`include "drbac_map.svh"

module drbac_alu
	import drbac_pkg::*;
#(
	parameter int WIDTH = 8
) (
	input  wire logic        core_clk_i,
	input  wire logic        sys_rst_i,
	input  wire logic        hsel_i,
	input  wire logic [31:0] haddr_i,
	input  wire logic [1:0]  htrans_i,
	input  wire logic        hwrite_i,
	input  wire logic [2:0]  hsize_i,
	input  wire logic [31:0] hwdata_i,
	input  wire logic        hready_i,
	output logic             hreadyout_o,
	output logic             hresp_o,
	output logic [31:0]      hrdata_o,
	output logic             late_cycle_pulse_o,
	output logic             alu_check_o,
	output logic             any_mcheck_o,
	output logic             clock_start_o,
	output logic             hard_stop_o,
	output logic             recomplement_o
);

	// -----------------------------------------------------------------
	// elaboration check
	// -----------------------------------------------------------------
	if (WIDTH != 8) begin : g_width_chk
		$error("drbac_alu serves an 8-bit slice only");
	end
	// every checked pair and tapped position must lie in the slice
	if (`DRBAC_PAIRS != WIDTH + 3) begin : g_pair_chk
		$error("drbac_alu pairs must be z, sum0, sum4 and carry0");
	end
	if (`DRBAC_SUM4_POS >= WIDTH ||
		`DRBAC_CARRY_LATCH >= WIDTH) begin : g_pos_chk
		$error("drbac_alu tap positions outside the slice");
	end

	// -----------------------------------------------------------------
	// functions
	// -----------------------------------------------------------------
	// one bit position: {carry out, sum}
	function automatic drbac_slice_t bit_slice(
		input logic a,
		input logic b,
		input logic cin,
		input logic is_and,
		input logic is_or,
		input logic connect
	);
		drbac_slice_t r;
		r = 2'h0;
		// and and or ignore cin; add and xor share one sum path
		if (is_and) begin
			r[0] = a & b;
		end else if (is_or) begin
			r[0] = a | b;
		end else begin
			r[0] = a ^ b ^ cin;
		end
		// connect forces no carry out
		r[1] = connect ? 1'b0 : ((a & b) | ((a ^ b) & cin));
		return r;
	endfunction

	function automatic logic reg_hit(
		input logic [7:0] addr,
		input logic [7:0] ofs
	);
		return addr == ofs;
	endfunction

	function automatic logic dest_hit(
		input logic [2:0] dest,
		input logic [2:0] code
	);
		return dest == code;
	endfunction

	// -----------------------------------------------------------------
	// registers
	// -----------------------------------------------------------------
	logic [WIDTH-1:0] opa_reg;
	logic [WIDTH-1:0] opb_reg;
	logic [2:0]       fn_reg;
	logic [2:0]       dest_reg;
	logic             cstop_reg;
	logic             exec_reg;
	logic [WIDTH-1:0] z_reg;
	logic             carry0_reg;
	logic             recomp_reg;
	logic             chk_seen_reg;
	logic [WIDTH-1:0] status_reg;
	logic [WIDTH-1:0] mcheck_reg;
	logic             cin_latch_reg;
	logic             hard_reg;
	logic             wind_reg;
	logic             xind_reg;
	logic [`DRBAC_PAIRS-1:0] fault_reg;
	// bus data phase
	logic             dp_wr_reg;
	logic             dp_rd_reg;
	logic [7:0]       dp_addr_reg;

	// -----------------------------------------------------------------
	// ahb-lite address phase and decode
	// -----------------------------------------------------------------
	wire        ap_take = hsel_i & htrans_i[1] & hready_i;
	wire        wr_en   = dp_wr_reg;
	wire [31:0] wd      = hwdata_i;
	wire        wr_opnd = wr_en & reg_hit(dp_addr_reg, `DRBAC_OFS_OPERAND);
	wire        wr_ctl  = wr_en & reg_hit(dp_addr_reg, `DRBAC_OFS_CONTROL);
	wire        wr_exec = wr_en & reg_hit(dp_addr_reg, `DRBAC_OFS_EXECUTE);
	wire        wr_stat = wr_en & reg_hit(dp_addr_reg, `DRBAC_OFS_STATUS);
	wire        wr_mchk = wr_en & reg_hit(dp_addr_reg, `DRBAC_OFS_MCHECK);
	wire        wr_stop = wr_en & reg_hit(dp_addr_reg, `DRBAC_OFS_STOP);
	wire        wr_flt  = wr_en & reg_hit(dp_addr_reg, `DRBAC_OFS_FAULT);

	// data phase runs one cycle behind the taken address phase
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			dp_wr_reg   <= 1'b0;
			dp_rd_reg   <= 1'b0;
			dp_addr_reg <= `DRBAC_RST_BYTE;
		end else if (hready_i) begin
			dp_wr_reg   <= ap_take & hwrite_i;
			dp_rd_reg   <= ap_take & ~hwrite_i;
			dp_addr_reg <= haddr_i[7:0];
		end
	end

	// -----------------------------------------------------------------
	// function decode and control lines
	// -----------------------------------------------------------------
	drbac_fn_e fn;
	assign fn = drbac_fn_e'(fn_reg);

	wire is_and    = (fn == DRBAC_FN_AND);
	wire is_or     = (fn == DRBAC_FN_OR);
	wire is_xor    = (fn == DRBAC_FN_XOR);
	wire is_logic  = is_and | is_or | is_xor;
	// add: carry path only; logic select and connect stay low
	wire logic_select_line = is_and | is_or;
	wire connect_line      = is_and | is_or | is_xor;
	wire carry_path_line   = 1'b1;
	wire force_carry = (fn == DRBAC_FN_FORCE) |
		(fn == DRBAC_FN_FORCE_LATCH);
	wire gate_carry  = (fn == DRBAC_FN_ADD_LATCH) |
		(fn == DRBAC_FN_FORCE_LATCH) |
		(fn == DRBAC_FN_CIN_LATCH);
	wire use_cin     = (fn == DRBAC_FN_CIN_LATCH);

	// carry into bit 7; logic ops see no carry in
	wire cin7 = carry_path_line & ~is_logic &
		(cin_latch_reg | force_carry);

	// -----------------------------------------------------------------
	// ripple chain, bit 7 toward bit 0
	// -----------------------------------------------------------------
	// carry_in[i] enters position i from position i + 1
	logic [WIDTH-1:0] carry_in;
	logic [WIDTH-1:0] sum;
	logic [WIDTH-1:0] carry_out;

	always_comb begin
		drbac_slice_t s;
		s = 2'h0;
		carry_in        = '0;
		sum             = '0;
		carry_out       = '0;
		carry_in[WIDTH-1] = cin7;
		for (int i = WIDTH - 1; i >= 0; i--) begin
			s = bit_slice(opa_reg[i], opb_reg[i], carry_in[i],
				logic_select_line & is_and,
				logic_select_line & is_or, connect_line);
			sum[i]       = s[0];
			carry_out[i] = s[1];
			// only adds pass carries on
			if (i > 0) begin
				carry_in[i-1] = ~is_logic & s[1];
			end
		end
	end

	wire carry0 = carry_out[0];

	// -----------------------------------------------------------------
	// dual-rail pairs and check
	// -----------------------------------------------------------------
	// z pairs, then sum0, sum4, carry0
	wire [`DRBAC_PAIRS-1:0] rail_plus = {carry0, sum[`DRBAC_SUM4_POS],
		sum[0], sum};
	// minus rail: inverted plus rail, a fault bit flips its pair
	wire [`DRBAC_PAIRS-1:0] rail_minus = ~rail_plus ^ fault_reg;
	wire [`DRBAC_PAIRS-1:0] pair_ok    = rail_plus ^ rail_minus;
	wire alu_check = ~&pair_ok;

	// -----------------------------------------------------------------
	// late cycle effects
	// -----------------------------------------------------------------
	// t4 is the edge that ends the late-cycle pulse
	wire t4         = exec_reg;
	wire stop_block = cstop_reg & alu_check;
	wire dest_stat  = dest_hit(dest_reg, `DRBAC_DEST_STATUS);
	wire s3_now     = status_reg[`DRBAC_CARRY_LATCH];
	wire s3_set = (carry0 & gate_carry) |
		(dest_stat & sum[`DRBAC_CARRY_LATCH]);
	wire cin_set = use_cin & s3_now;
	wire compl_add = force_carry;
	wire recomp_set = compl_add & ~carry0;

	// -----------------------------------------------------------------
	// status and machine check next state
	// -----------------------------------------------------------------
	// a late-pulse status load or carry latch update outranks a software status write in the same cycle
	logic [WIDTH-1:0] status_next;
	always_comb begin
		status_next = status_reg;
		if (wr_stat) begin
			status_next = wd[WIDTH-1:0];
		end
		if (t4) begin
			if (dest_stat) begin
				status_next = sum;
			end
			if (cin_set) begin
				status_next[`DRBAC_CARRY_LATCH] = 1'b0;
			end
			if (s3_set) begin
				status_next[`DRBAC_CARRY_LATCH] = 1'b1;
			end
		end
	end

	logic [WIDTH-1:0] mcheck_next;
	always_comb begin
		mcheck_next = mcheck_reg;
		if (wr_mchk) begin
			mcheck_next = mcheck_reg & ~wd[WIDTH-1:0];
		end
		if (t4 & alu_check) begin
			mcheck_next[`DRBAC_MCHK_ALU] = 1'b1;
		end
	end

	// -----------------------------------------------------------------
	// stop and indicating latches, execute gate
	// -----------------------------------------------------------------
	// a set in the same cycle beats a software clear
	wire wind_set = t4 & dest_hit(dest_reg, `DRBAC_DEST_W) & ~stop_block;
	wire xind_set = t4 & dest_hit(dest_reg, `DRBAC_DEST_X) & ~stop_block;
	wire hard_set = t4 & stop_block;
	wire stop_clr_hard = wr_stop & wd[`DRBAC_STOP_HARD];
	wire stop_clr_w    = wr_stop & wd[`DRBAC_STOP_WIND];
	wire stop_clr_x    = wr_stop & wd[`DRBAC_STOP_XIND];
	wire hard_next = hard_set | (hard_reg & ~stop_clr_hard);
	wire wind_next = wind_set | (wind_reg & ~stop_clr_w);
	wire xind_next = xind_set | (xind_reg & ~stop_clr_x);
	// a halted clock refuses further cycles
	wire exec_next = wr_exec & ~hard_reg;
	wire cin_next  = t4 ? cin_set : cin_latch_reg;

	// -----------------------------------------------------------------
	// control registers
	// -----------------------------------------------------------------
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			opa_reg   <= `DRBAC_RST_BYTE;
			opb_reg   <= `DRBAC_RST_BYTE;
			fn_reg    <= `DRBAC_RST_FIELD;
			dest_reg  <= `DRBAC_RST_FIELD;
			cstop_reg <= 1'b0;
			fault_reg <= '0;
		end else begin
			if (wr_opnd) begin
				opa_reg <= wd[WIDTH-1:0];
				opb_reg <= wd[`DRBAC_OPB_LSB +: WIDTH];
			end
			if (wr_ctl) begin
				fn_reg    <= wd[`DRBAC_CTL_FN_LSB +: 3];
				dest_reg  <= wd[`DRBAC_CTL_DEST_LSB +: 3];
				cstop_reg <= wd[`DRBAC_CTL_CSTOP];
			end
			if (wr_flt) begin
				fault_reg <= wd[`DRBAC_PAIRS-1:0];
			end
		end
	end

	// -----------------------------------------------------------------
	// cycle state
	// -----------------------------------------------------------------
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			exec_reg      <= 1'b0;
			status_reg    <= `DRBAC_RST_BYTE;
			mcheck_reg    <= `DRBAC_RST_BYTE;
			cin_latch_reg <= 1'b0;
			hard_reg      <= 1'b0;
			wind_reg      <= 1'b0;
			xind_reg      <= 1'b0;
		end else begin
			exec_reg      <= exec_next;
			status_reg    <= status_next;
			mcheck_reg    <= mcheck_next;
			cin_latch_reg <= cin_next;
			hard_reg      <= hard_next;
			wind_reg      <= wind_next;
			xind_reg      <= xind_next;
		end
	end

	// captured at each late pulse
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			z_reg        <= `DRBAC_RST_BYTE;
			carry0_reg   <= 1'b0;
			recomp_reg   <= 1'b0;
			chk_seen_reg <= 1'b0;
		end else if (t4) begin
			z_reg        <= sum;
			carry0_reg   <= carry0;
			recomp_reg   <= recomp_set;
			chk_seen_reg <= alu_check;
		end
	end

	// -----------------------------------------------------------------
	// read mux and outputs
	// -----------------------------------------------------------------
	wire [31:0] rd_opnd = {16'h0000, opb_reg, opa_reg};
	wire [31:0] rd_ctl  = {25'h0000000, cstop_reg, dest_reg, fn_reg};
	wire [31:0] rd_res  = {20'h00000, cin_latch_reg, chk_seen_reg,
		recomp_reg, carry0_reg, z_reg};
	wire [31:0] rd_stat = {24'h000000, status_reg};
	wire [31:0] rd_mchk = {24'h000000, mcheck_reg};
	wire [31:0] rd_stop = {29'h00000000, xind_reg, wind_reg, hard_reg};
	wire [31:0] rd_flt  = {21'h000000, fault_reg};

	// unmapped offsets read zero
	logic [31:0] rd_sel;
	always_comb begin
		rd_sel = 32'h00000000;
		unique case (dp_addr_reg)
			`DRBAC_OFS_OPERAND: rd_sel = rd_opnd;
			`DRBAC_OFS_CONTROL: rd_sel = rd_ctl;
			`DRBAC_OFS_RESULT:  rd_sel = rd_res;
			`DRBAC_OFS_STATUS:  rd_sel = rd_stat;
			`DRBAC_OFS_MCHECK:  rd_sel = rd_mchk;
			`DRBAC_OFS_STOP:    rd_sel = rd_stop;
			`DRBAC_OFS_FAULT:   rd_sel = rd_flt;
			default:            rd_sel = 32'h00000000;
		endcase
	end

	assign hrdata_o           = dp_rd_reg ? rd_sel : 32'h00000000;
	assign hreadyout_o        = 1'b1;
	assign hresp_o            = 1'b0;
	assign late_cycle_pulse_o = exec_reg;
	assign alu_check_o        = chk_seen_reg;
	assign any_mcheck_o       = |mcheck_reg;
	assign clock_start_o      = ~hard_reg;
	assign hard_stop_o        = hard_reg;
	assign recomplement_o     = recomp_reg;

endmodule

// file: drbac_alu_asserts.sv
// concurrent checks on the ports of the byte alu slice
// assumes: bound to drbac_alu, one clock, synchronous reset
`timescale 1ns/1ps
`include "drbac_map.svh"
module drbac_alu_asserts (
	input wire logic        core_clk_i,
	input wire logic        sys_rst_i,
	input wire logic        hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0]  htrans_i,
	input wire logic        hwrite_i,
	input wire logic [2:0]  hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic        hready_i,
	input wire logic        hreadyout_o,
	input wire logic        hresp_o,
	input wire logic [31:0] hrdata_o,
	input wire logic        late_cycle_pulse_o,
	input wire logic        alu_check_o,
	input wire logic        any_mcheck_o,
	input wire logic        clock_start_o,
	input wire logic        hard_stop_o,
	input wire logic        recomplement_o
);
	// ---------------------------------------------------------
	// data phase trackers
	// ---------------------------------------------------------
	logic exec_dp;
	logic rd_dp;
	wire  taken = hsel_i & htrans_i[1] & hready_i;
	wire  is_ex = haddr_i[7:0] == `DRBAC_OFS_EXECUTE;
	always_ff @(posedge core_clk_i) begin
		exec_dp <= !sys_rst_i & taken & hwrite_i & is_ex;
		rd_dp   <= !sys_rst_i & taken & !hwrite_i;
	end
	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (sys_rst_i);
	a_exec_fire: assert property (
		exec_dp && !hard_stop_o |=> late_cycle_pulse_o)
		else $error("late pulse missing after execute");
	a_pulse_cause: assert property (
		late_cycle_pulse_o |-> $past(exec_dp) && !$past(hard_stop_o))
		else $error("late pulse without accepted execute");
	a_recomp_hold: assert property (
		!$past(late_cycle_pulse_o) |-> $stable(recomplement_o))
		else $error("recomplement moved outside late edge");
	a_check_hold: assert property (
		!$past(late_cycle_pulse_o) |-> $stable(alu_check_o))
		else $error("alu check moved outside late edge");
	a_check_any: assert property (
		$rose(alu_check_o) |-> any_mcheck_o)
		else $error("alu check without machine check");
	a_stop_cause: assert property (
		$rose(hard_stop_o) |-> alu_check_o)
		else $error("hard stop without alu check");
	a_start_drop: assert property (clock_start_o == !hard_stop_o)
		else $error("clock start not inverse of hard stop");
	a_bus_okay: assert property (hreadyout_o && !hresp_o)
		else $error("bus slave stalled or erred");
	a_rdata_idle: assert property (!rd_dp |-> hrdata_o == 32'h0)
		else $error("read data outside read data phase");
	c_pulse: cover property (late_cycle_pulse_o);
	c_stop: cover property ($rose(hard_stop_o));
	c_recomp: cover property ($rose(recomplement_o));
endmodule
bind drbac_alu drbac_alu_asserts u_chk (.core_clk_i(core_clk_i),
	.sys_rst_i(sys_rst_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
	.htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i),
	.hwdata_i(hwdata_i), .hready_i(hready_i), .hreadyout_o(hreadyout_o),
	.hresp_o(hresp_o), .hrdata_o(hrdata_o),
	.late_cycle_pulse_o(late_cycle_pulse_o), .alu_check_o(alu_check_o),
	.any_mcheck_o(any_mcheck_o), .clock_start_o(clock_start_o),
	.hard_stop_o(hard_stop_o), .recomplement_o(recomplement_o));

// file: drbac_map.svh
// register offsets, field positions and reset values of the byte alu
// assumes: included by the alu slice and its package users, by bare name
//
// What this block does
// - add raises only the carry-path line
// - add/xor sum is a^b^incoming carry
// - add carries on both bits, or one plus carry
// - xor asserts connect, killing every carry out
// - and: bit set only when both set
// - or: bit set when either is set
// - logic operations force no carry in
// - carries ripple bit 7 toward bit 0
// - carries pass only during add; corrector taps 0,4
// - complement add without carry out requests recomplement
// - carry latch set at late pulse on gated carry
// - functions 4, 5, 6 gate carry to latch
// - destination 6 loads status; z bit 3 sets latch
// - function 6 moves carry latch into carry-in
// - functions 1 and 5 insert a forced carry
// - check z pairs, sum0, sum4, carry0 pairs
// - equal rails in any pair raise alu check
// - check stop plus check blocks w/x latches
// - alu check sets machine check bit 7
// - check raises any-check; check stop halts clock
// - function field decode 0 through 7
`ifndef DRBAC_MAP_SVH
`define DRBAC_MAP_SVH

// -----------------------------------------------------------------
// register byte offsets
// -----------------------------------------------------------------
`define DRBAC_OFS_OPERAND 8'h00
`define DRBAC_OFS_CONTROL 8'h04
`define DRBAC_OFS_EXECUTE 8'h08
`define DRBAC_OFS_RESULT  8'h0c
`define DRBAC_OFS_STATUS  8'h10
`define DRBAC_OFS_MCHECK  8'h14
`define DRBAC_OFS_STOP    8'h18
`define DRBAC_OFS_FAULT   8'h1c

// -----------------------------------------------------------------
// field positions
// -----------------------------------------------------------------
`define DRBAC_OPB_LSB       8
`define DRBAC_CTL_FN_LSB    0
`define DRBAC_CTL_DEST_LSB  3
`define DRBAC_CTL_CSTOP     6
`define DRBAC_RES_CARRY0    8
`define DRBAC_RES_RECOMP    9
`define DRBAC_RES_CHECK     10
`define DRBAC_RES_CIN       11
`define DRBAC_CARRY_LATCH   3
`define DRBAC_MCHK_ALU      7
`define DRBAC_STOP_HARD     0
`define DRBAC_STOP_WIND     1
`define DRBAC_STOP_XIND     2
`define DRBAC_SUM4_POS      4
`define DRBAC_PAIRS         11

// -----------------------------------------------------------------
// destination codes and reset values
// -----------------------------------------------------------------
`define DRBAC_DEST_W      3'h1
`define DRBAC_DEST_X      3'h2
`define DRBAC_DEST_STATUS 3'h6
`define DRBAC_RST_BYTE    8'h00
`define DRBAC_RST_FIELD   3'h0

`endif

// file: drbac_pkg.sv
// types shared by the byte alu slice
// assumes: compiled before the slice
package drbac_pkg;

	// function field decode, in field value order 0..7
	typedef enum logic [2:0] {
		DRBAC_FN_ADD,
		DRBAC_FN_FORCE,
		DRBAC_FN_AND,
		DRBAC_FN_OR,
		DRBAC_FN_ADD_LATCH,
		DRBAC_FN_FORCE_LATCH,
		DRBAC_FN_CIN_LATCH,
		DRBAC_FN_XOR
	} drbac_fn_e;

	typedef logic [1:0] drbac_slice_t;

endpackage

// file: drbac_ustore.sv
// control store model: hands out function and destination fields
// assumes: combinational lookup, one microword per step index
`timescale 1ns/1ps
module drbac_ustore (
	input  wire logic [4:0] step_i,
	output logic      [2:0] fn_o,
	output logic      [2:0] dest_o
);
	// every function code in turn; destinations 0, 1, 2 and status
	assign fn_o   = step_i[2:0];
	assign dest_o = (step_i[4:3] == 2'h3) ? 3'h6 : {1'b0, step_i[4:3]};
endmodule

// file: testbench.sv
// self-checking bench of the byte alu slice against a bench model
// assumes: drbac_alu, drbac_ustore and the checker compiled before
`timescale 1ns/1ps
`include "drbac_map.svh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
	error_cnt++; $display("unexpected %0t got %h exp %h", $time, g, e); end end
module testbench;
	logic        core_clk_i = 0;
	logic        sys_rst_i = 1;
	logic        hsel_i = 0;
	logic        hwrite_i = 0;
	logic [1:0]  htrans_i = 0;
	logic [31:0] haddr_i = 0;
	logic [31:0] hwdata_i = 0;
	logic [31:0] rd;
	logic [4:0]  step = 0;
	logic [7:0]  a, b, z, st, stw;
	logic [8:0]  s;
	logic        cinl, cin, cout, rc, wl, xl, fire;
	wire  logic  rdy, hresp, pulse, alu_chk, any_chk, clk_start, hstop, recomp;
	wire  logic [31:0] hrdata;
	wire  logic [2:0]  fn, dest;
	int          error_cnt = 0;
	int          samples_checked = 0;

	always #10 core_clk_i = ~core_clk_i;

	drbac_alu #(.WIDTH(8)) u_dut (.core_clk_i(core_clk_i),
		.sys_rst_i(sys_rst_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
		.htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(3'h2),
		.hwdata_i(hwdata_i), .hready_i(rdy), .hreadyout_o(rdy),
		.hresp_o(hresp), .hrdata_o(hrdata), .late_cycle_pulse_o(pulse),
		.alu_check_o(alu_chk), .any_mcheck_o(any_chk),
		.clock_start_o(clk_start), .hard_stop_o(hstop),
		.recomplement_o(recomp));
	drbac_ustore u_store (.step_i(step), .fn_o(fn), .dest_o(dest));

	function automatic logic [7:0] rev(input logic [7:0] v);
		for (int i = 0; i < 8; i++) rev[i] = v[7-i];
	endfunction

	task automatic give_verdict();
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task automatic rdy_wait();
		int n;
		n = 0;
		do begin
			@(posedge core_clk_i);
			n++;
		end while (rdy !== 1'b1 && n < 20);
		if (n >= 20) begin
			error_cnt++;
			$display("unexpected %0t bus hang", $time);
			give_verdict();
		end
	endtask

	// single word transfer: address phase, then data phase
	task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] d);
		hsel_i   <= 1'b1;
		haddr_i  <= {24'h0, ad};
		htrans_i <= 2'h2;
		hwrite_i <= w;
		rdy_wait();
		htrans_i <= 2'h0;
		hwdata_i <= d;
		rdy_wait();
		rd = hrdata;
	endtask

	task automatic pulse_wait(output logic seen);
		seen = 1'b0;
		for (int n = 0; n < 8 && !seen; n++) begin
			@(posedge core_clk_i);
			seen = (pulse === 1'b1);
		end
	endtask

	initial begin
		void'($urandom(32'h2cbd));
		repeat (4) @(posedge core_clk_i);
		sys_rst_i <= 1'b0;
		for (int o = 0; o <= 8'h40; o += 4) begin
			bus(1'b0, o[7:0], 32'h0);
			`CHK(rd, 32'h0)
		end
		`CHK(clk_start, 1'b1)
		st = 8'h0;
		cinl = 1'b0;
		wl = 1'b0;
		xl = 1'b0;
		for (int i = 0; i < 64; i++) begin
			step <= i[4:0];
			a = $urandom;
			b = $urandom;
			bus(1'b1, `DRBAC_OFS_OPERAND, {16'h0, b, a});
			bus(1'b1, `DRBAC_OFS_CONTROL, {26'h0, dest, fn});
			bus(1'b1, `DRBAC_OFS_EXECUTE, 32'h1);
			pulse_wait(fire);
			`CHK(fire, 1'b1)
			cin = (fn inside {3'h2, 3'h3, 3'h7}) ? 1'b0 :
				(cinl | fn == 3'h1 | fn == 3'h5);
			s = {1'b0, rev(a)} + {1'b0, rev(b)} + {8'h0, cin};
			case (fn)
				3'h2: z = a & b;
				3'h3: z = a | b;
				3'h7: z = a ^ b;
				default: z = rev(s[7:0]);
			endcase
			cout = (fn inside {3'h2, 3'h3, 3'h7}) ? 1'b0 : s[8];
			rc = (fn == 3'h1 || fn == 3'h5) & !cout;
			stw = (dest == 3'h6) ? z : st;
			if (fn == 3'h6 && st[3]) stw[3] = 1'b0;
			if ((cout && fn inside {3'h4, 3'h5, 3'h6}) || (dest == 3'h6 && z[3]))
				stw[3] = 1'b1;
			cinl = (fn == 3'h6) && st[3];
			st = stw;
			wl |= dest == 3'h1;
			xl |= dest == 3'h2;
			bus(1'b0, `DRBAC_OFS_RESULT, 32'h0);
			`CHK(rd[7:0], z)
			`CHK(rd[31:8], {20'h0, cinl, 1'b0, rc, cout})
			bus(1'b0, `DRBAC_OFS_STATUS, 32'h0);
			`CHK(rd[7:0], st)
			`CHK(recomp, rc)
		end
		bus(1'b0, `DRBAC_OFS_STOP, 32'h0);
		`CHK(rd[2:0], {xl, wl, 1'b0})
		// broken rail pair, with and without check stop
		for (int cs = 1; cs >= 0; cs--) begin
			bus(1'b1, `DRBAC_OFS_STOP, 32'h7);
			bus(1'b1, `DRBAC_OFS_MCHECK, 32'hff);
			bus(1'b1, `DRBAC_OFS_FAULT, 32'h1 << ($urandom % 11));
			bus(1'b1, `DRBAC_OFS_CONTROL, {25'h0, cs[0], 3'h1, 3'h0});
			bus(1'b1, `DRBAC_OFS_EXECUTE, 32'h1);
			pulse_wait(fire);
			bus(1'b0, `DRBAC_OFS_MCHECK, 32'h0);
			`CHK(rd[7:0], 8'h80)
			`CHK({alu_chk, any_chk}, 2'h3)
			`CHK({hstop, clk_start}, {cs[0], !cs[0]})
			bus(1'b0, `DRBAC_OFS_STOP, 32'h0);
			`CHK(rd[2:0], cs[0] ? 3'h1 : 3'h2)
			bus(1'b1, `DRBAC_OFS_EXECUTE, 32'h1);
			pulse_wait(fire);
			`CHK(fire, !cs[0])
		end
		bus(1'b1, `DRBAC_OFS_FAULT, 32'h0);
		bus(1'b1, `DRBAC_OFS_STOP, 32'h7);
		bus(1'b1, `DRBAC_OFS_MCHECK, 32'hff);
		@(posedge core_clk_i);
		`CHK({hstop, clk_start, any_chk}, 3'h2)
		give_verdict();
	end
endmodule
